// ### energy_pulse_regs.vh
`ifndef ENERGY_PULSE_REGS_VH
`define ENERGY_PULSE_REGS_VH

// Register port geometry
`define REG_ADDR_W          6
`define REG_WDATA_W         16
`define REG_RDATA_W         40

// Register addresses
`define ADDR_MODE           6'h06
`define ADDR_IRQ_ENABLE     6'h08
`define ADDR_IRQ_STATUS     6'h09
`define ADDR_IRQ_RSTATUS    6'h0a
`define ADDR_POWER_OFFSET   6'h0d
`define ADDR_PULSE_NUM      6'h0f
`define ADDR_PULSE_DEN      6'h10
`define ADDR_LINE_CYCLE     6'h14

// Field positions
`define MODE_CYCLE_BIT      7
`define IRQ_CYCLE_END_BIT   2

// Field widths
`define SAMPLE_W            16
`define OFFSET_W            16
`define DIV_W               12
`define HALF_CYC_W          14
`define PULSE_INT_W         24
`define LINE_INT_W          40
`define FRAC_W              8

// Reset values
`define PULSE_DEN_RESET     12'h03f
`define PULSE_NUM_RESET     12'h000
`define OFFSET_RESET        16'h0000
`define HALF_CYC_RESET      14'h0000

// One accumulator update every this many clocks
`define UPDATE_PERIOD       4
`define UPDATE_LAST         2'h3

`endif

// ### energy_pulse_line_accum.v
`timescale 1ns/1ps
`include "energy_pulse_regs.vh"

// Behaviour
// - A signed 16-bit power offset is added to every power sample.
// - Offset value 256 equals one sample LSB.
// - A separate 32-bit pulse accumulator continuously sums the power sample.
// - A raw pulse occurs when the pulse accumulator MSB rises zero to one.
// - The pulse accumulator takes one sample every four clocks.
// - Raw pulse rate scales by (numerator+1)/(denominator+1) to the output for numerator up to denominator; above it, one output per raw pulse.
// - Reset loads denominator 3Fh and numerator 0h.
// - Mode register bit 7 set selects line-cycle accumulation.
// - After the first period, which starts at the mode write, line-cycle sums cover whole half cycles between zero crossings.
// - The 14-bit half-cycle count register sets the period length.
// - The line-cycle result is a 40-bit signed value that may overflow.
// - Each period end sets the cycle-end flag, status bit 2.
// - With cycle-end enabled, the open-drain interrupt pin is driven low.
// - A new period starts right after each one while the mode stays set.
// - Address 14h reads the cycle result and writes the half-cycle count.
// - Accumulation is signed; negative samples reduce the totals.
// - Accumulators wrap around on overflow and underflow and keep counting.
module energy_pulse_line_accum
(
    input  wire        i_clock,
    input  wire        i_resetn,
    input  wire [15:0] i_power_sample,
    input  wire        i_zero_cross,
    input  wire [5:0]  i_reg_addr,
    input  wire [15:0] i_reg_wdata,
    input  wire        i_reg_we,
    input  wire        i_reg_re,
    output wire [39:0] o_reg_rdata,
    output wire        o_calibration_pulse_out,
    output wire        o_irq_n_out,
    output wire        o_irq_n_oe
);

    localparam ST_IDLE = 2'b01;
    localparam ST_RUN  = 2'b10;

    // Configuration registers
    reg  [15:0] power_offset_ff;
    reg  [11:0] pulse_divider_numerator_ff;
    reg  [11:0] pulse_divider_denominator_ff;
    reg  [13:0] half_cycle_count_ff;
    reg         cycle_mode_bit_ff;
    reg         cycle_end_enable_ff;
    reg         cycle_end_flag_ff;
    reg         nxt_cycle_end_flag;

    // Datapath state
    reg  [1:0]  phase_ff;
    reg  [31:0] pulse_acc_ff;
    reg  [12:0] div_acc_ff;
    reg  [12:0] nxt_div_acc;
    reg         cal_pulse_ff;
    reg         nxt_cal_pulse;
    reg  [47:0] line_acc_ff;
    reg  [47:0] nxt_line_acc;
    reg  [39:0] line_cycle_energy_result_ff;
    reg  [39:0] nxt_line_result;
    reg  [13:0] remain_ff;
    reg  [13:0] nxt_remain;
    reg  [1:0]  state_ff;
    reg  [1:0]  nxt_state;
    reg         cycle_end_evt;
    reg  [39:0] reg_rdata_ff;
    reg  [39:0] nxt_rdata;
    reg         irq_oe_ff;
    reg         irq_out_ff;

    wire        tick;
    wire [24:0] corrected;
    wire [31:0] pulse_sum;
    wire        raw_pulse;
    wire [13:0] div_sum;
    wire [13:0] div_limit;
    wire        rd_clear;

    assign o_reg_rdata             = reg_rdata_ff;
    assign o_calibration_pulse_out = cal_pulse_ff;
    assign o_irq_n_out             = irq_out_ff;
    assign o_irq_n_oe              = irq_oe_ff;

    assign tick = (phase_ff == `UPDATE_LAST);

    assign corrected = {i_power_sample[15], i_power_sample, 8'h00}
                     + {{9{power_offset_ff[15]}}, power_offset_ff};

    assign pulse_sum = pulse_acc_ff + {{7{corrected[24]}}, corrected};

    // MSB rising edge of the pulse accumulator
    assign raw_pulse = tick & ~pulse_acc_ff[31] & pulse_sum[31];

    // Rate divider sums, two bits wider than the 12-bit ratio registers
    assign div_sum   = {1'b0, div_acc_ff}
                     + {2'b00, pulse_divider_numerator_ff} + 14'h0001;
    assign div_limit = {2'b00, pulse_divider_denominator_ff} + 14'h0001;

    assign rd_clear = i_reg_re & (i_reg_addr == `ADDR_IRQ_RSTATUS);

    // Register writes; unmapped and read-only addresses are ignored
    always @(posedge i_clock or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            power_offset_ff              <= `OFFSET_RESET;
            pulse_divider_numerator_ff   <= `PULSE_NUM_RESET;
            pulse_divider_denominator_ff <= `PULSE_DEN_RESET;
            half_cycle_count_ff          <= `HALF_CYC_RESET;
            cycle_mode_bit_ff            <= 1'b0;
            cycle_end_enable_ff          <= 1'b0;
        end
        else if (i_reg_we)
        begin
            case (i_reg_addr)
                `ADDR_POWER_OFFSET:
                    power_offset_ff <= i_reg_wdata;
                `ADDR_PULSE_NUM:
                    pulse_divider_numerator_ff <= i_reg_wdata[11:0];
                `ADDR_PULSE_DEN:
                    pulse_divider_denominator_ff <= i_reg_wdata[11:0];
                // write side of the shared address
                `ADDR_LINE_CYCLE:
                    half_cycle_count_ff <= i_reg_wdata[13:0];
                `ADDR_MODE:
                    cycle_mode_bit_ff <= i_reg_wdata[`MODE_CYCLE_BIT];
                `ADDR_IRQ_ENABLE:
                    cycle_end_enable_ff <= i_reg_wdata[`IRQ_CYCLE_END_BIT];
                default:
                    cycle_mode_bit_ff <= cycle_mode_bit_ff;
            endcase
        end
    end

    // Update phase and pulse accumulator
    always @(posedge i_clock or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            phase_ff     <= 2'h0;
            pulse_acc_ff <= 32'h0000_0000;
        end
        else
        begin
            phase_ff <= phase_ff + 2'h1;
            if (tick)
                pulse_acc_ff <= pulse_sum;
        end
    end

    // fractional divider; at most one output per raw pulse
    always @*
    begin
        nxt_div_acc   = div_acc_ff;
        nxt_cal_pulse = 1'b0;
        if (raw_pulse)
        begin
            if (div_sum >= div_limit)
            begin
                nxt_div_acc   = div_sum[12:0] - div_limit[12:0];
                nxt_cal_pulse = 1'b1;
            end
            else
            begin
                nxt_div_acc = div_sum[12:0];
            end
        end
    end

    always @(posedge i_clock or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            div_acc_ff   <= 13'h0000;
            cal_pulse_ff <= 1'b0;
        end
        else
        begin
            div_acc_ff   <= nxt_div_acc;
            cal_pulse_ff <= nxt_cal_pulse;
        end
    end

    // Line-cycle sequencer
    always @*
    begin
        nxt_state       = state_ff;
        nxt_line_acc    = line_acc_ff;
        nxt_remain      = remain_ff;
        nxt_line_result = line_cycle_energy_result_ff;
        cycle_end_evt   = 1'b0;
        case (state_ff)
            ST_IDLE:
            begin
                // mode bit starts the first period
                if (cycle_mode_bit_ff)
                begin
                    nxt_state    = ST_RUN;
                    nxt_line_acc = 48'h0000_0000_0000;
                    nxt_remain   = half_cycle_count_ff;
                end
            end
            ST_RUN:
            begin
                if (!cycle_mode_bit_ff)
                begin
                    nxt_state = ST_IDLE;
                end
                else
                begin
                    if (tick)
                        nxt_line_acc = line_acc_ff
                                     + {{23{corrected[24]}}, corrected};
                    // count half cycles at zero crossings
                    if (i_zero_cross)
                    begin
                        if (remain_ff <= 14'h0001)
                        begin
                            nxt_line_result = nxt_line_acc[47:8];
                            nxt_line_acc    = 48'h0000_0000_0000;
                            nxt_remain      = half_cycle_count_ff;
                            cycle_end_evt   = 1'b1;
                        end
                        else
                        begin
                            nxt_remain = remain_ff - 14'h0001;
                        end
                    end
                end
            end
            default:
                nxt_state = ST_IDLE;
        endcase
    end

    always @(posedge i_clock or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            state_ff                    <= ST_IDLE;
            line_acc_ff                 <= 48'h0000_0000_0000;
            remain_ff                   <= 14'h0000;
            line_cycle_energy_result_ff <= 40'h00_0000_0000;
        end
        else
        begin
            state_ff                    <= nxt_state;
            line_acc_ff                 <= nxt_line_acc;
            remain_ff                   <= nxt_remain;
            line_cycle_energy_result_ff <= nxt_line_result;
        end
    end

    // sticky flag, a new event beats the read clear
    always @*
    begin
        nxt_cycle_end_flag = cycle_end_flag_ff;
        if (cycle_end_evt)
            nxt_cycle_end_flag = 1'b1;
        else if (rd_clear)
            nxt_cycle_end_flag = 1'b0;
    end

    // Read data, registered; unmapped addresses read zero
    always @*
    begin
        nxt_rdata = reg_rdata_ff;
        if (i_reg_re)
        begin
            nxt_rdata = 40'h00_0000_0000;
            case (i_reg_addr)
                `ADDR_POWER_OFFSET:
                    nxt_rdata[15:0] = power_offset_ff;
                `ADDR_PULSE_NUM:
                    nxt_rdata[11:0] = pulse_divider_numerator_ff;
                `ADDR_PULSE_DEN:
                    nxt_rdata[11:0] = pulse_divider_denominator_ff;
                // read side of the shared address
                `ADDR_LINE_CYCLE:
                    nxt_rdata = line_cycle_energy_result_ff;
                `ADDR_MODE:
                    nxt_rdata[`MODE_CYCLE_BIT] = cycle_mode_bit_ff;
                `ADDR_IRQ_ENABLE:
                    nxt_rdata[`IRQ_CYCLE_END_BIT] = cycle_end_enable_ff;
                `ADDR_IRQ_STATUS,
                `ADDR_IRQ_RSTATUS:
                    nxt_rdata[`IRQ_CYCLE_END_BIT] = cycle_end_flag_ff;
                default:
                    nxt_rdata = 40'h00_0000_0000;
            endcase
        end
    end

    always @(posedge i_clock or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            cycle_end_flag_ff <= 1'b0;
            reg_rdata_ff      <= 40'h00_0000_0000;
            irq_oe_ff         <= 1'b0;
            irq_out_ff        <= 1'b0;
        end
        else
        begin
            cycle_end_flag_ff <= nxt_cycle_end_flag;
            reg_rdata_ff      <= nxt_rdata;
            irq_oe_ff         <= nxt_cycle_end_flag & cycle_end_enable_ff;
            irq_out_ff        <= 1'b0;
        end
    end

endmodule

// ### energy_pulse_line_accum_asserts.sv
`timescale 1ns/1ps
`include "energy_pulse_regs.vh"
// Port-level checks for the pulse and line-cycle block
module energy_pulse_line_accum_asserts
(
    input wire        i_clock,
    input wire        i_resetn,
    input wire [15:0] i_power_sample,
    input wire        i_zero_cross,
    input wire [5:0]  i_reg_addr,
    input wire [15:0] i_reg_wdata,
    input wire        i_reg_we,
    input wire        i_reg_re,
    input wire [39:0] o_reg_rdata,
    input wire        o_calibration_pulse_out,
    input wire        o_irq_n_out,
    input wire        o_irq_n_oe
);
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_resetn);

    // Read of the clearing status address
    wire clr_rd = i_reg_re && (i_reg_addr == `ADDR_IRQ_RSTATUS);

    // Pulses are one clock wide and at least four clocks apart
    a_pulse_spacing: assert property (
        o_calibration_pulse_out |=> !o_calibration_pulse_out [*3])
        else $error("calibration pulses too close");
    // Open-drain pin only ever pulls low
    a_irq_pin_low: assert property (
        o_irq_n_out == 1'b0)
        else $error("interrupt pin driven high");
    a_irq_cause: assert property (
        $rose(o_irq_n_oe) |-> $past(i_zero_cross) ||
        $past(i_zero_cross, 2) || $past(i_reg_we, 2))
        else $error("interrupt without crossing");
    // Flag stands until the clearing read
    a_flag_holds: assert property (
        o_irq_n_oe && !i_reg_we && !clr_rd |=> o_irq_n_oe)
        else $error("interrupt dropped early");
    a_flag_clears: assert property (
        o_irq_n_oe && clr_rd && !i_zero_cross && !$past(i_zero_cross)
        |=> !o_irq_n_oe)
        else $error("interrupt not cleared by read");
    // Read data stands between reads
    a_rdata_holds: assert property (
        !i_reg_re && !$past(i_reg_re) |=> $stable(o_reg_rdata))
        else $error("read data changed without read");
    a_den_readback: assert property (
        i_reg_we && i_reg_addr == `ADDR_PULSE_DEN ##1
        i_reg_re && i_reg_addr == `ADDR_PULSE_DEN |=>
        o_reg_rdata == {28'h0, $past(i_reg_wdata[11:0], 2)})
        else $error("denominator readback wrong");
    a_reset_quiet: assert property (
        $rose(i_resetn) |-> o_reg_rdata == 40'h0 &&
        !o_calibration_pulse_out && !o_irq_n_oe)
        else $error("outputs active out of reset");

    // Main scenarios reached
    c_pulse: cover property (o_calibration_pulse_out);
    c_irq: cover property ($rose(o_irq_n_oe));
    c_result: cover property (i_reg_re && i_reg_addr == `ADDR_LINE_CYCLE);
endmodule

bind energy_pulse_line_accum energy_pulse_line_accum_asserts u_chk (.*);

// ### calib_pulse_counter.sv
`timescale 1ns/1ps
// Pulse counter as a calibration bench would use it
module calib_pulse_counter
(
    input  wire        i_clock,
    input  wire        i_resetn,
    input  wire        i_pulse,
    input  wire        i_clear,
    output wire [15:0] o_count
);
    reg [15:0] count_ff;

    // Tally of pulses, cleared at the start of each gate window
    always @(posedge i_clock or negedge i_resetn)
    begin
        if (!i_resetn)
            count_ff <= 16'h0000;
        else if (i_clear)
            count_ff <= 16'h0000;
        else if (i_pulse)
            count_ff <= count_ff + 16'h0001;
    end
    assign o_count = count_ff;
endmodule

// ### energy_pulse_line_accum_test.sv
`timescale 1ns/1ps
`include "energy_pulse_regs.vh"
module energy_pulse_line_accum_test;
    reg         i_clock;
    reg         i_resetn;
    reg  [15:0] i_power_sample;
    reg         i_zero_cross;
    reg  [5:0]  i_reg_addr;
    reg  [15:0] i_reg_wdata;
    reg         i_reg_we;
    reg         i_reg_re;
    wire [39:0] o_reg_rdata;
    wire        o_calibration_pulse_out;
    wire        o_irq_n_out;
    wire        o_irq_n_oe;
    wire [15:0] pulse_count;
    reg         count_clear;
    reg         zc_on;
    reg  [15:0] next_sample;
    integer     zc_gap;
    integer     n_zc;
    integer     fails;
    integer     n_tests;
    // Interrupt line with its pull-up
    wire        irq_line = o_irq_n_oe ? o_irq_n_out : 1'b1;

    energy_pulse_line_accum dut (
        .i_clock                 (i_clock),
        .i_resetn                (i_resetn),
        .i_power_sample          (i_power_sample),
        .i_zero_cross            (i_zero_cross),
        .i_reg_addr              (i_reg_addr),
        .i_reg_wdata             (i_reg_wdata),
        .i_reg_we                (i_reg_we),
        .i_reg_re                (i_reg_re),
        .o_reg_rdata             (o_reg_rdata),
        .o_calibration_pulse_out (o_calibration_pulse_out),
        .o_irq_n_out             (o_irq_n_out),
        .o_irq_n_oe              (o_irq_n_oe)
    );
    calib_pulse_counter meter (.i_clock(i_clock), .i_resetn(i_resetn),
        .i_pulse(o_calibration_pulse_out), .i_clear(count_clear),
        .o_count(pulse_count));

    // Clock, 5 ns period
    initial
    begin
        i_clock = 1'b0;
        forever #2.5 i_clock = ~i_clock;
    end

    // Crossings every 200 clocks; the sample steps right after one
    initial
    begin
        i_zero_cross = 1'b0;
        zc_gap = 0;
        n_zc = 0;
        forever
        begin
            @(posedge i_clock);
            #1;
            if (i_zero_cross)
            begin
                n_zc = n_zc + 1;
                i_power_sample = next_sample;
            end
            zc_gap = zc_on ? zc_gap + 1 : 0;
            i_zero_cross = (zc_gap == 200);
            if (zc_gap == 200)
                zc_gap = 0;
        end
    end

    task print_verdict;
    begin
        $display("Comparisons %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    end
    endtask

    task check(input [39:0] got, input [39:0] exp);
    begin
        n_tests = n_tests + 1;
        if (got !== exp)
        begin
            fails = fails + 1;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    end
    endtask

    task do_reset;
    begin
        i_resetn = 1'b0;
        repeat (6) @(posedge i_clock);
        #1;
        i_resetn = 1'b1;
    end
    endtask

    task wr(input [5:0] a, input [15:0] d);
    begin
        i_reg_addr = a;
        i_reg_wdata = d;
        i_reg_we = 1'b1;
        @(posedge i_clock);
        #1;
        i_reg_we = 1'b0;
        @(posedge i_clock);
        #1;
    end
    endtask

    task rd(input [5:0] a, input [39:0] exp);
    begin
        i_reg_addr = a;
        i_reg_re = 1'b1;
        @(posedge i_clock);
        #1;
        i_reg_re = 1'b0;
        @(posedge i_clock);
        #1;
        check(o_reg_rdata, exp);
    end
    endtask

    task wait_zc(input integer n);
        integer k;
        begin
            for (k = 0; k < 2000 && n_zc < n; k = k + 1)
            begin
                @(posedge i_clock);
                #1;
            end
            if (n_zc < n)
            begin
                fails = fails + 1;
                $display("Error at %0t: got %h expected %h", $time, n_zc, n);
                print_verdict;
            end
            else
            begin
                repeat (2) @(posedge i_clock);
                #1;
            end
        end
    endtask

    // Pulses expected over 2100 ticks of sample 7fffh
    function [39:0] exp_pulses(input [11:0] num, input [11:0] den);
        reg [31:0] acc;
        reg [31:0] nxt;
        integer    sum;
        integer    k;
        begin
            acc = 32'h0;
            sum = 0;
            exp_pulses = 40'h0;
            for (k = 0; k < 2100; k = k + 1)
            begin
                nxt = acc + 32'h007fff00;
                if (!acc[31] && nxt[31])
                begin
                    sum = sum + num + 1;
                    if (sum > den)
                    begin
                        sum = sum - den - 1;
                        exp_pulses = exp_pulses + 40'h1;
                    end
                end
                acc = nxt;
            end
        end
    endfunction

    task test_regs;
    begin
        do_reset;
        rd(`ADDR_PULSE_NUM, 40'h0);
        rd(`ADDR_PULSE_DEN, 40'h3f);
        rd(6'h3f, 40'h0);
        i_reg_addr = `ADDR_PULSE_DEN;
        i_reg_wdata = 16'hf8b9;
        i_reg_we = 1'b1;
        @(posedge i_clock);
        #1;
        i_reg_we = 1'b0;
        rd(`ADDR_PULSE_DEN, 40'h8b9);
        $display("test_regs done");
    end
    endtask

    task test_pulse(input [11:0] num, input [11:0] den);
    begin
        do_reset;
        wr(`ADDR_PULSE_NUM, {4'h0, num});
        wr(`ADDR_PULSE_DEN, {4'h0, den});
        i_power_sample = 16'h7fff;
        count_clear = 1'b1;
        @(posedge i_clock);
        #1;
        count_clear = 1'b0;
        repeat (8400) @(posedge i_clock);
        #1;
        check({24'h0, pulse_count}, exp_pulses(num, den));
        $display("test_pulse %h/%h done", num, den);
    end
    endtask

    task test_line;
    begin
        do_reset;
        wr(`ADDR_POWER_OFFSET, 16'h0080);
        wr(`ADDR_LINE_CYCLE, 16'h0002);
        wr(`ADDR_IRQ_ENABLE, 16'h0004);
        i_power_sample = 16'h0020;
        next_sample = 16'h0020;
        wr(`ADDR_MODE, 16'h0080);
        zc_on = 1'b1;
        wait_zc(3);
        next_sample = 16'hffc0;
        wait_zc(4);
        rd(`ADDR_LINE_CYCLE, 40'h0000000cb2);
        rd(`ADDR_IRQ_STATUS, 40'h4);
        check({39'h0, irq_line}, 40'h0);
        rd(`ADDR_IRQ_RSTATUS, 40'h4);
        rd(`ADDR_IRQ_STATUS, 40'h0);
        check({39'h0, irq_line}, 40'h1);
        wait_zc(6);
        rd(`ADDR_LINE_CYCLE, 40'hffffffe732);
        rd(`ADDR_IRQ_STATUS, 40'h4);
        rd(`ADDR_MODE, 40'h80);
        rd(`ADDR_IRQ_ENABLE, 40'h4);
        rd(`ADDR_POWER_OFFSET, 40'h80);
        // Mode off: crossings go on, no period may end
        rd(`ADDR_IRQ_RSTATUS, 40'h4);
        wr(`ADDR_MODE, 16'h0000);
        wait_zc(8);
        rd(`ADDR_IRQ_STATUS, 40'h0);
        rd(`ADDR_LINE_CYCLE, 40'hffffffe732);
        zc_on = 1'b0;
        $display("test_line done");
    end
    endtask

    // Main sequence
    initial
    begin
        fails = 0;
        n_tests = 0;
        i_power_sample = 16'h0000;
        i_reg_addr = 6'h00;
        i_reg_wdata = 16'h0000;
        i_reg_we = 1'b0;
        i_reg_re = 1'b0;
        count_clear = 1'b0;
        zc_on = 1'b0;
        next_sample = 16'h0000;
        test_regs;
        test_pulse(12'h000, 12'h000);
        test_pulse(12'h001, 12'h002);
        test_line;
        print_verdict;
    end
endmodule
